// ---- nvm_ctrl.sv ----
// nvm control and status register with byte flags, supply inhibit and launch sequencing
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
// How it works
// - with byte-flag mode on, a data-window read in 0780h-07ffh loads the readout bit with that byte flag.
// - with byte-flag mode off, the readout bit reads one whatever is read.
// - with auto-erase set the next write sequence erases the page first, otherwise it only programs.
// - with byte-flag mode on, a data-window write in 0780h-07ffh sets that location's byte flag.
// - with byte-flag mode off, every byte flag is forced to zero.
// - inhibit clears when the supply is low and sets only after the supply has been good for 2 ms.
module nvm_ctrl #(
    parameter int SETTLE = nvm_ctrl_pkg::SETTLE_CYCLES,
    parameter int PAGE_BYTES = 128
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // core accesses to the data window
    input wire logic win_rd,
    input wire logic win_wr,
    input wire logic [10:0] win_addr,
    input wire logic [7:0] win_wdata,
    input wire logic supply_ok,
    output logic page_wr,
    output logic [6:0] page_idx,
    output logic [7:0] page_data,
    output logic erase_busy,
    output logic prog_busy,
    output logic [1:0] target_space_select,
    output logic irq
);
    localparam int PW = $clog2(PAGE_BYTES);

    logic ack_q;
    logic flag_readout_bit_q;
    logic auto_erase_enable_q;
    logic page_load_enable_q;
    logic byte_flag_mode_q;
    logic inhibit_q;
    logic err_q;
    logic [nvm_ctrl_pkg::FLAG_COUNT-1:0] flags_q;
    logic [PAGE_BYTES-1:0] loaded_q;
    logic [31:0] settle_q;
    logic [1:0] space_q;
    logic [4:0] cnt_q;
    logic erase_pend_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_mask_q;
    logic page_wr_q;
    logic [6:0] page_idx_q;
    logic [7:0] page_data_q;
    logic [31:0] rdata_q;
    nvm_ctrl_pkg::prog_state_t st_q;

    wire req = wb_cyc_i && wb_stb_i && !ack_q;
    wire wr_lane0 = req && wb_we_i && wb_sel_i[0];
    wire sel_ctrl = wb_adr_i == nvm_ctrl_pkg::ADDR_CTRL_STATUS;
    wire sel_launch = wb_adr_i == nvm_ctrl_pkg::ADDR_LAUNCH;
    wire sel_istat = wb_adr_i == nvm_ctrl_pkg::ADDR_IRQ_STATUS;
    wire sel_imask = wb_adr_i == nvm_ctrl_pkg::ADDR_IRQ_MASK;
    wire wr_ctrl = wr_lane0 && sel_ctrl;
    wire wr_launch = wr_lane0 && sel_launch;
    wire wr_istat = wr_lane0 && sel_istat;
    wire wr_imask = wr_lane0 && sel_imask;
    wire in_flag = (win_addr & 11'h780) == nvm_ctrl_pkg::FLAG_BASE;
    wire [6:0] flag_idx = win_addr[6:0];
    wire [PW-1:0] pidx = win_addr[PW-1:0];
    wire key1 = wr_launch && wb_dat_i[7:4] == nvm_ctrl_pkg::KEY_FIRST;
    wire key2 = wr_launch && wb_dat_i[7:4] == nvm_ctrl_pkg::KEY_SECOND;
    wire running = st_q == nvm_ctrl_pkg::ST_ERASE || st_q == nvm_ctrl_pkg::ST_PROG;
    wire start = st_q == nvm_ctrl_pkg::ST_ARMED && key2;
    // programming with the supply inhibited aborts and flags an error
    wire start_bad = start && !inhibit_q;
    wire start_ok = start && inhibit_q;
    wire abort = running && !supply_ok;
    wire done = st_q == nvm_ctrl_pkg::ST_PROG && cnt_q == 5'd0 && !abort;
    // a page byte may be loaded once; a second load is dropped
    wire load_ok = win_wr && page_load_enable_q && !loaded_q[pidx] && !running;
    wire inhibit_lost = inhibit_q && !supply_ok;
    wire [2:0] irq_set = {inhibit_lost, start_bad || abort, done};
    wire [7:0] ctrl_rd = {flag_readout_bit_q, auto_erase_enable_q, page_load_enable_q,
        byte_flag_mode_q, inhibit_q, err_q, 2'b00};
    wire [7:0] launch_rd = {4'h0, page_load_enable_q, space_q, running};
    wire [31:0] rd_mux = sel_ctrl ? {24'h0, ctrl_rd} :
        sel_launch ? {24'h0, launch_rd} :
        sel_istat ? {29'h0, irq_stat_q} :
        sel_imask ? {29'h0, irq_mask_q} : 32'h0;

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign page_wr = page_wr_q;
    assign page_idx = page_idx_q;
    assign page_data = page_data_q;
    assign erase_busy = st_q == nvm_ctrl_pkg::ST_ERASE;
    assign prog_busy = st_q == nvm_ctrl_pkg::ST_PROG;
    assign target_space_select = space_q;
    assign irq = |(irq_stat_q & irq_mask_q);

    // single-cycle answer: ack one edge after the request, dropped the next
    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q <= req;
            rdata_q <= req ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            auto_erase_enable_q <= nvm_ctrl_pkg::CTRL_RESET[nvm_ctrl_pkg::BIT_AUTO_ERASE];
            page_load_enable_q <= nvm_ctrl_pkg::CTRL_RESET[nvm_ctrl_pkg::BIT_PAGE_LOAD];
            byte_flag_mode_q <= nvm_ctrl_pkg::CTRL_RESET[nvm_ctrl_pkg::BIT_FLAG_MODE];
            irq_mask_q <= 3'h0;
        end else begin
            if (wr_ctrl) begin
                auto_erase_enable_q <= wb_dat_i[nvm_ctrl_pkg::BIT_AUTO_ERASE];
                page_load_enable_q <= wb_dat_i[nvm_ctrl_pkg::BIT_PAGE_LOAD];
                byte_flag_mode_q <= wb_dat_i[nvm_ctrl_pkg::BIT_FLAG_MODE];
            end
            if (wr_imask)
                irq_mask_q <= wb_dat_i[2:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst)
            flag_readout_bit_q <= nvm_ctrl_pkg::CTRL_RESET[nvm_ctrl_pkg::BIT_FLAG_OUT];
        else if (!byte_flag_mode_q)
            flag_readout_bit_q <= 1'b1;
        else if (win_rd && in_flag)
            flag_readout_bit_q <= flags_q[flag_idx];
    end

    always_ff @(posedge mclk) begin
        if (rst || !byte_flag_mode_q)
            flags_q <= '0;
        else if (win_wr && in_flag)
            flags_q[flag_idx] <= 1'b1;
    end

    // supply good must persist for the full settle count before inhibit rises
    always_ff @(posedge mclk) begin
        if (rst || !supply_ok) begin
            inhibit_q <= 1'b0;
            settle_q <= 32'h0;
        end else if (settle_q < SETTLE - 1) begin
            settle_q <= settle_q + 32'h1;
        end else begin
            inhibit_q <= 1'b1;
        end
    end

    // page buffer write port toward the array; loaded marks clear at commit
    always_ff @(posedge mclk) begin
        if (rst) begin
            loaded_q <= '0;
            page_wr_q <= 1'b0;
            page_idx_q <= 7'h0;
            page_data_q <= 8'h0;
        end else begin
            page_wr_q <= load_ok;
            if (load_ok) begin
                loaded_q[pidx] <= 1'b1;
                page_idx_q <= win_addr[6:0];
                page_data_q <= win_wdata;
            end
            if (done || abort)
                loaded_q <= '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= nvm_ctrl_pkg::ST_IDLE;
            space_q <= 2'b00;
            cnt_q <= 5'd0;
            erase_pend_q <= 1'b0;
        end else begin
            case (st_q)
                nvm_ctrl_pkg::ST_IDLE: begin
                    if (key1) begin
                        st_q <= nvm_ctrl_pkg::ST_ARMED;
                        space_q <= wb_dat_i[2:1];
                    end
                end
                nvm_ctrl_pkg::ST_ARMED: begin
                    if (start_ok) begin
                        erase_pend_q <= auto_erase_enable_q;
                        cnt_q <= 5'(nvm_ctrl_pkg::PROG_CYCLES - 1);
                        st_q <= auto_erase_enable_q ? nvm_ctrl_pkg::ST_ERASE
                            : nvm_ctrl_pkg::ST_PROG;
                    end else if (wr_launch) begin
                        st_q <= nvm_ctrl_pkg::ST_IDLE;
                    end
                end
                nvm_ctrl_pkg::ST_ERASE: begin
                    if (abort) begin
                        st_q <= nvm_ctrl_pkg::ST_IDLE;
                    end else if (cnt_q == 5'd0) begin
                        erase_pend_q <= 1'b0;
                        cnt_q <= 5'(nvm_ctrl_pkg::PROG_CYCLES - 1);
                        st_q <= nvm_ctrl_pkg::ST_PROG;
                    end else begin
                        cnt_q <= cnt_q - 5'd1;
                    end
                end
                default: begin
                    if (abort || cnt_q == 5'd0)
                        st_q <= nvm_ctrl_pkg::ST_IDLE;
                    else
                        cnt_q <= cnt_q - 5'd1;
                end
            endcase
        end
    end

    // error stays until the next accepted launch; set beats any clear
    always_ff @(posedge mclk) begin
        if (rst)
            err_q <= 1'b0;
        else if (start_bad || abort)
            err_q <= 1'b1;
        else if (start_ok)
            err_q <= 1'b0;
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_irq
            always_ff @(posedge mclk) begin
                if (rst)
                    irq_stat_q[g] <= 1'b0;
                else if (irq_set[g])
                    irq_stat_q[g] <= 1'b1;
                else if (wr_istat && wb_dat_i[g])
                    irq_stat_q[g] <= 1'b0;
            end
        end
    endgenerate
endmodule

// ---- nvm_ctrl_pkg.sv ----
// package: register map, field positions, reset values and timing for the nvm control block
package nvm_ctrl_pkg;
    // byte addresses on the wishbone bus; only irq status and mask are word-aligned
    localparam logic [7:0] ADDR_CTRL_STATUS = 8'hd2;
    localparam logic [7:0] ADDR_LAUNCH = 8'hd1;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'hd4;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'hd8;
    // control/status field positions
    localparam int BIT_FLAG_OUT = 7;
    localparam int BIT_AUTO_ERASE = 6;
    localparam int BIT_PAGE_LOAD = 5;
    localparam int BIT_FLAG_MODE = 4;
    localparam int BIT_INHIBIT = 3;
    localparam int BIT_ERR = 2;
    localparam logic [7:0] CTRL_RESET = 8'h80;
    // launch register fields
    localparam logic [3:0] KEY_FIRST = 4'h5;
    localparam logic [3:0] KEY_SECOND = 4'ha;
    // flag range of the data window
    localparam logic [10:0] FLAG_BASE = 11'h780;
    localparam int FLAG_COUNT = 128;
    // interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    localparam int IRQ_INHIBIT_LOST = 2;
    // supply settle delay, erase/program cycle count and sequencer states
    localparam int CLK_MHZ = 100;
    localparam int SETTLE_US = 2000;
    localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
    localparam int PROG_CYCLES = 16;
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_ERASE, ST_PROG} prog_state_t;
endpackage

// ---- nvm_ctrl_monitor.sv ----
// port-level assertions for the nvm control block
`timescale 1ns/1ps
module nvm_ctrl_monitor #(parameter int SETTLE = 20) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic win_wr,
    input wire logic [10:0] win_addr,
    input wire logic supply_ok,
    input wire logic page_wr,
    input wire logic [6:0] page_idx,
    input wire logic erase_busy,
    input wire logic prog_busy
);
    logic mode_q;
    int ok_cnt_q;
    wire [6:0] win_byte = win_addr[6:0];
    wire at_ctrl = wb_adr_i == nvm_ctrl_pkg::ADDR_CTRL_STATUS;
    wire rd_ctrl = wb_ack_o && !wb_we_i && at_ctrl;
    // mode copy lags the design by one edge, harmless since reads never follow that close
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_q <= 1'b0;
            ok_cnt_q <= 0;
        end else begin
            if (wb_ack_o && wb_we_i && at_ctrl && wb_sel_i[0])
                mode_q <= wb_dat_i[4];
            ok_cnt_q <= !supply_ok ? 0 : (ok_cnt_q < 1000000 ? ok_cnt_q + 1 : ok_cnt_q);
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    readout_off_a: assert property (rd_ctrl && !mode_q |-> wb_dat_o[7])
        else $error("readout low with flag mode off");
    inhibit_low_a: assert property (rd_ctrl && !$past(supply_ok) && !$past(supply_ok, 2)
        |-> !wb_dat_o[3]) else $error("inhibit set with supply low");
    inhibit_set_a: assert property (rd_ctrl && ok_cnt_q > SETTLE + 3 |-> wb_dat_o[3])
        else $error("inhibit not set after settle delay");
    page_cause_a: assert property (page_wr |-> $past(win_wr) && page_idx == $past(win_byte))
        else $error("page load without matching window write");
    erase_then_prog_a: assert property ($fell(erase_busy) && $past(supply_ok) |-> prog_busy)
        else $error("erase not followed by programming");
    busy_excl_a: assert property (!(erase_busy && prog_busy))
        else $error("erase and program overlap");
    cover property (rd_ctrl && wb_dat_o[3]);
    cover property (page_wr);
    cover property ($fell(erase_busy));
endmodule
bind nvm_ctrl nvm_ctrl_monitor #(.SETTLE(SETTLE)) mon (.mclk(mclk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .win_wr(win_wr), .win_addr(win_addr), .supply_ok(supply_ok), .page_wr(page_wr),
    .page_idx(page_idx), .erase_busy(erase_busy), .prog_busy(prog_busy));

// ---- eeprom_control_byte_flags_tb.sv ----
// self-checking bench for the nvm control block
`timescale 1ns/1ps
module eeprom_control_byte_flags_tb;
    localparam logic [7:0] CS = nvm_ctrl_pkg::ADDR_CTRL_STATUS;
    localparam logic [7:0] LA = nvm_ctrl_pkg::ADDR_LAUNCH;
    localparam logic [7:0] IS = nvm_ctrl_pkg::ADDR_IRQ_STATUS;
    logic mclk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
    logic win_rd = 1'b0, win_wr = 1'b0, supply_ok = 1'b1, page_wr, erase_busy, prog_busy;
    logic saw_e, saw_p;
    logic [7:0] adr = 8'h00, win_wdata = 8'h00, page_data;
    logic [10:0] win_addr = 11'h000;
    logic [31:0] dat = 32'h0, dat_o;
    logic [6:0] page_idx;
    logic [1:0] space;
    int num_errors = 0, cmp_count = 0, cycles = 0;
    nvm_ctrl #(.SETTLE(20)) dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .win_rd(win_rd), .win_wr(win_wr), .win_addr(win_addr),
        .win_wdata(win_wdata), .supply_ok(supply_ok), .page_wr(page_wr), .page_idx(page_idx),
        .page_data(page_data), .erase_busy(erase_busy), .prog_busy(prog_busy),
        .target_space_select(space), .irq(irq));
    always #5 mclk = ~mclk;
    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // a hang anywhere ends in the common report
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [31:0] q);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        do @(posedge mclk); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        check(what, q, exp);
    endtask
    task automatic win(input logic w, input logic [10:0] a, input logic [7:0] d);
        @(posedge mclk);
        win_rd <= !w;
        win_wr <= w;
        win_addr <= a;
        win_wdata <= d;
        @(posedge mclk);
        win_rd <= 1'b0;
        win_wr <= 1'b0;
    endtask
    // erase and program take a fixed 16 cycles each, so 60 cycles cover a whole run
    task automatic launch(input logic [7:0] first);
        wr(LA, first);
        wr(LA, 8'ha0);
        saw_e = 1'b0;
        saw_p = 1'b0;
        repeat (60) begin
            @(posedge mclk);
            if (erase_busy === 1'b1) saw_e = 1'b1;
            if (prog_busy === 1'b1) saw_p = 1'b1;
        end
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rdc("ctrl reset", CS, 32'h80);
        rdc("unmapped", 8'hf0, 32'h0);
        repeat (30) @(posedge mclk);
        win(1'b0, 11'h785, 8'h00);
        rdc("inhibit and readout", CS, 32'h88);
        wr(CS, 8'h10);
        win(1'b1, 11'h785, 8'h11);
        win(1'b0, 11'h785, 8'h00);
        rdc("flag set", CS, 32'h98);
        win(1'b0, 11'h7ff, 8'h00);
        rdc("flag clear", CS, 32'h18);
        wr(CS, 8'h00);
        rdc("mode off", CS, 32'h88);
        wr(CS, 8'h10);
        win(1'b0, 11'h785, 8'h00);
        rdc("flags wiped", CS, 32'h18);
        wr(CS, 8'h60);
        win(1'b1, 11'h005, 8'ha5);
        #1;
        check("page load", {16'h0, page_wr, page_idx, page_data}, 32'h85a5);
        win(1'b1, 11'h005, 8'h5a);
        #1;
        check("page reload", {31'h0, page_wr}, 32'h0);
        launch(8'h52);
        check("erase and program", {29'h0, space, saw_e & saw_p}, 32'h3);
        rdc("done event", IS, 32'h1);
        wr(IS, 8'h01);
        wr(CS, 8'h20);
        launch(8'h50);
        check("no erase", {30'h0, saw_e, saw_p}, 32'h1);
        @(posedge mclk);
        supply_ok <= 1'b0;
        repeat (3) @(posedge mclk);
        rdc("inhibit low", CS, 32'ha0);
        rdc("inhibit lost event", IS, 32'h5);
        // a launch with the supply inhibited must not run and must raise the error flag
        launch(8'h50);
        check("inhibited launch", {30'h0, saw_e, saw_p}, 32'h0);
        rdc("error flag", CS, 32'ha4);
        rdc("error event", IS, 32'h7);
        wr(nvm_ctrl_pkg::ADDR_IRQ_MASK, 8'h04);
        #1;
        check("irq masked in", {31'h0, irq}, 32'h1);
        wr(IS, 8'h07);
        #1;
        check("irq cleared", {31'h0, irq}, 32'h0);
        end_sim();
    end
endmodule
